//--- bench/adc_dev_model.sv
// Device model: codec status and command registers, six engine register sets.
// Assumes reads answer one cycle later; eop_hit acts on engine 0 only.
`timescale 1ns/1ps
module adc_dev_model #(
	parameter logic [31:0] STAT_IN = 32'ha503_1234
) (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        reset,
	// Register port
	input wire logic [7:0]  dev_addr,
	input wire logic [31:0] dev_wdata,
	input wire logic        dev_wr,
	input wire logic        dev_rd,
	output logic     [31:0] dev_rdata,
	// Engine events
	input wire logic        eop_hit,
	output logic            engine_halted
);
	logic [31:0] cst_q, cmd_q, ptr_q [6];
	logic [19:0] gpo_q;
	logic [7:0]  ecmd_q [6], irq_q [6];
	logic        pause_q;
	int          e;
	assign e = (dev_addr - 8'h20) >> 3;
	assign engine_halted = pause_q || !ecmd_q[0][0];
	always @(posedge ref_clk) begin
		if (reset) begin
			{cst_q, cmd_q, gpo_q, pause_q, dev_rdata} <= '0;
			ecmd_q <= '{default: '0};
			irq_q <= '{default: '0};
			ptr_q <= '{default: '0};
		end else begin
			dev_rdata <= ~dev_rdata;
			cst_q <= {STAT_IN[31:24], cst_q[23:19], 1'b0, STAT_IN[17:0]};
			// Page completes on a slot request; a second one pauses
			if (eop_hit) begin
				irq_q[0] <= irq_q[0] | {6'h0, irq_q[0][0], 1'b1};
				pause_q <= pause_q || irq_q[0][0];
			end
			if (dev_wr) begin
				if (dev_addr == 8'h08)
					cst_q[23:19] <= dev_wdata[23:19];
				if (dev_addr == 8'h0c)
					cmd_q <= dev_wdata;
				// GPIO pin data for slot 12
				if (dev_addr == 8'h04)
					gpo_q <= dev_wdata[19:0];
				// Enable steps pointer by eight; link entries not walked
				if (e < 6 && dev_addr[2:0] == 3'h0) begin
					ecmd_q[e] <= dev_wdata[7:0] & 8'h09;
					if (dev_wdata[0] && !ecmd_q[e][0])
						ptr_q[e] <= ptr_q[e] + 32'h8;
				end
				if (e < 6 && dev_addr[2:0] == 3'h4)
					ptr_q[e] <= {dev_wdata[31:2], 2'h0};
			end
			if (dev_rd) begin
				// GPIO status: valid flag reads zero, pins echo slot 12
				if (dev_addr == 8'h00)
					dev_rdata <= {12'h0, gpo_q};
				if (dev_addr == 8'h08)
					dev_rdata <= cst_q;
				if (dev_addr == 8'h0c)
					dev_rdata <= cmd_q;
				if (e < 6 && dev_addr[2:0] == 3'h1) begin
					dev_rdata <= {24'h0, irq_q[e]};
					irq_q[e] <= 8'h0;
					pause_q <= pause_q && e != 0;
				end
			end
		end
	end
endmodule

//--- bench/adc_host_properties.sv
// Port assertions for adc_host.
// Assumes it is bound to adc_host; reset is synchronous, active high.
`timescale 1ns/1ps
module adc_host_chk (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        reset,
	// Device port
	input wire logic [7:0]  dev_addr,
	input wire logic [31:0] dev_wdata,
	input wire logic        dev_wr,
	input wire logic        dev_rd,
	input wire logic        engine_halted,
	// Memory port
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic        mem_wr
);
	// --------
	// Properties
	// --------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire eng_w = dev_wr && dev_addr >= 8'h20 && dev_addr[2:0] == 3'h0;
	wire en_w  = eng_w && dev_wdata[0];
	wire cmd_w = dev_wr && dev_addr == 8'h0c;
	a_clear_first: assert property (en_w |->
		$past(dev_rd, 4) && $past(dev_addr, 4) == dev_addr + 8'h1)
		else $error("no status read before enable");
	a_dir_first: assert property (en_w |-> $past(dev_wr) && $past(dev_addr) == dev_addr &&
		!$past(dev_wdata[0]) && $past(dev_wdata[3]) == dev_addr[3] && dev_wdata[3] == dev_addr[3])
		else $error("direction not set before enable");
	a_ptr_first: assert property (en_w |-> $past(dev_wr, 2) &&
		$past(dev_addr, 2) == dev_addr + 8'h4 && $past(dev_wdata[1:0], 2) == 2'h0)
		else $error("table pointer not loaded before enable");
	a_stop_halted: assert property (eng_w && !dev_wdata[0] && !$past(dev_wr) |->
		$past(engine_halted) && $past(engine_halted, 2))
		else $error("engine disabled while running");
	a_cmd_valid: assert property (cmd_w |-> dev_wdata[16])
		else $error("command sent without valid flag");
	a_cmd_select: assert property (cmd_w |-> dev_wdata[23:22] <= 2'h1)
		else $error("command sent to illegal codec");
	a_desc_pair: assert property (mem_wr && !$past(mem_wr) |=>
		mem_wr && mem_addr == $past(mem_addr) + 32'h4)
		else $error("descriptor words not paired");
	a_desc_flags: assert property (mem_wr && $past(mem_wr) |->
		!(mem_wdata[31] && mem_wdata[29]) ##1 !mem_wr)
		else $error("bad descriptor flag word");
	c_start: cover property (en_w);
	c_stop: cover property (eng_w && !dev_wdata[0] && !$past(dev_wr));
	c_desc: cover property (mem_wr ##1 mem_wr);
endmodule

bind adc_host adc_host_chk u_chk (
	.ref_clk, .reset, .dev_addr, .dev_wdata, .dev_wr, .dev_rd, .engine_halted,
	.mem_addr, .mem_wdata, .mem_wr
);

//--- bench/tb_adc_host.sv
// Self-checking bench for adc_host driving the device model.
// Assumes the checker bind and the device model are compiled first.
`timescale 1ns/1ps
`include "adc_regs.svh"
module tb_adc_host;
	localparam logic [31:0] ST_EXP = 32'ha503_1234;
	logic        ref_clk = 0, reset = 1, sw_wr = 0, sw_rd = 0, eop_hit = 0, rd_d = 0;
	logic [4:0]  sw_addr = 0;
	logic [31:0] sw_wdata = 0, rs = 53;
	logic [31:0] sw_rdata, dev_wdata, dev_rdata, mem_addr, mem_wdata, t, c, p;
	logic [7:0]  dev_addr;
	logic        dev_wr, dev_rd, mem_wr, engine_halted;
	logic [32:0] rq [$];
	logic [63:0] mq [$];
	logic [2:0]  fl [5] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h5};
	int          n_errors = 0, total_checks = 0, cyc = 0;
	always #12.5 ref_clk = ~ref_clk;
	adc_host uut (
		.ref_clk, .reset, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata,
		.dev_addr, .dev_wdata, .dev_wr, .dev_rd, .dev_rdata,
		.mem_addr, .mem_wdata, .mem_wr, .engine_halted
	);
	adc_dev_model #(.STAT_IN(ST_EXP)) dev (
		.ref_clk, .reset, .dev_addr, .dev_wdata, .dev_wr, .dev_rd, .dev_rdata,
		.eop_hit, .engine_halted
	);
	// --------
	// Tasks
	// --------
	function automatic logic [31:0] nxt();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wrap_up();
		$display("Total %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge ref_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e, input bit k);
		rq.push_back({!k, e});
		@(posedge ref_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge ref_clk);
		sw_rd <= 1'b0;
	endtask
	task automatic idle();
		for (int i = 0; i < 50; i++) begin
			rd(`ADC_HOST_STATUS, 32'h0, 0);
			@(negedge ref_clk);
			if (sw_rdata[0] === 1'b0)
				break;
		end
	endtask
	task automatic eop();
		@(posedge ref_clk);
		eop_hit <= 1'b1;
		@(posedge ref_clk);
		eop_hit <= 1'b0;
	endtask
	// --------
	// Monitor
	// --------
	always @(posedge ref_clk) begin
		logic [32:0] r;
		logic [63:0] m;
		rd_d <= sw_rd;
		cyc <= cyc + 1;
		if (rd_d) begin
			r = rq.pop_front();
			if (!r[32])
				chk("sw_rdata", sw_rdata, r[31:0]);
		end
		if (mem_wr) begin
			m = mq.size() ? mq.pop_front() : ~{mem_addr, mem_wdata};
			chk("mem_addr", mem_addr, m[63:32]);
			chk("mem_wdata", mem_wdata, m[31:0]);
		end
		if (cyc > 20000) begin
			n_errors++;
			wrap_up();
		end
	end
	// --------
	// Scenarios
	// --------
	initial begin
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		rd(`ADC_HOST_STATUS, 32'h0, 1);
		eop();
		for (int i = 0; i < 6; i++) begin
			t = nxt();
			wr(`ADC_HOST_TABLE, t);
			rd(`ADC_HOST_TABLE, t & ~32'h3, 1);
			wr(`ADC_HOST_CTRL, 32'h1 | (i << 8));
			idle();
			rd(`ADC_HOST_STATUS, (i == 0) ? 32'h100 : 32'h0, 1);
			chk("eng_cmd", dev.ecmd_q[i], {28'h0, i[0], 3'h1});
			chk("eng_ptr", dev.ptr_q[i], (t & ~32'h3) + 32'h8);
		end
		for (int s = 0; s < 4; s++) begin
			t = nxt();
			c = {t[31:24], s[1:0], 6'h0, t[15:0]};
			wr(`ADC_HOST_COMMAND, c);
			wr(`ADC_HOST_CTRL, 32'h4);
			idle();
			if (s < 2)
				p = c | 32'h1_0000;
			rd(`ADC_HOST_STATUS, (s < 2) ? 32'h0 : 32'h2, 1);
			chk("cmd_word", dev.cmd_q, p);
		end
		wr(`ADC_HOST_CTRL, 32'h8);
		idle();
		rd(`ADC_HOST_CODEC_STAT, ST_EXP, 1);
		foreach (fl[k]) begin
			c = nxt() & 32'hffff_fff8;
			t = nxt();
			p = {fl[k], 29'h0} | (nxt() & 32'hffff);
			wr(`ADC_HOST_DESC_ADDR, c);
			wr(`ADC_HOST_DESC_BASE, t);
			wr(`ADC_HOST_DESC_CTL, p);
			if (fl[k] != 3'h5)
				mq.push_back({c, t});
			if (fl[k] != 3'h5)
				mq.push_back({c + 32'h4, p});
			wr(`ADC_HOST_CTRL, 32'h10);
			idle();
			rd(`ADC_HOST_STATUS, (fl[k] == 3'h5) ? 32'h2 : 32'h0, 1);
		end
		wr(`ADC_HOST_CTRL, 32'h2);
		repeat (8) @(posedge ref_clk);
		chk("eng_run", dev.ecmd_q[0], 32'h1);
		eop();
		eop();
		idle();
		chk("eng_stop", dev.ecmd_q[0], 32'h0);
		wr(`ADC_HOST_CTRL, 32'h1);
		idle();
		rd(`ADC_HOST_STATUS, 32'h300, 1);
		chk("eng_resume", {31'h0, engine_halted}, 32'h0);
		wrap_up();
	end
endmodule

//--- hw/adc_desc_pack.sv
// Packs one region descriptor into its two memory words and checks it.
// Assumes the caller registers the words before they leave the block.
`timescale 1ns/1ps
`include "adc_regs.svh"

module adc_desc_pack
	import adc_pkg::*;
(
	// Descriptor fields
	input  wire logic [31:0] buf_base,
	input  wire logic [31:0] buf_size,
	input  wire logic        end_of_table_flag,
	input  wire logic        eop,
	input  wire logic        link,
	// Packed words
	output logic      [31:0] word0,
	output logic      [31:0] word1,
	output logic             legal
);

	// ----------------------------------------------------------------
	// Packing
	// ----------------------------------------------------------------
	always_comb begin
		word0 = buf_base;
		word1 = 32'h0;
		word1[`ADC_DESC_SIZE_W-1:0] = buf_size[`ADC_DESC_SIZE_W-1:0];
		word1[`ADC_DESC_EOT]        = end_of_table_flag;
		word1[`ADC_DESC_EOP]        = eop;
		word1[`ADC_DESC_LINK]       = link;
	end

	assign legal = (buf_size[31:`ADC_DESC_SIZE_W] == '0) && !(end_of_table_flag && link);

endmodule

//--- hw/adc_host.sv
// Host controller that programs the audio descriptor DMA and codec port.
// Assumes the device register port shares ref_clk and answers reads one cycle later.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "adc_regs.svh"

module adc_host
	import adc_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// Software port
	input  wire logic [4:0]  sw_addr,
	input  wire logic [31:0] sw_wdata,
	input  wire logic        sw_wr,
	input  wire logic        sw_rd,
	output logic      [31:0] sw_rdata,
	// Device register port
	output logic      [7:0]  dev_addr,
	output logic      [31:0] dev_wdata,
	output logic             dev_wr,
	output logic             dev_rd,
	input  wire logic [31:0] dev_rdata,
	// Descriptor memory write port
	output logic      [31:0] mem_addr,
	output logic      [31:0] mem_wdata,
	output logic             mem_wr,
	// Engine halted pin
	input  wire logic        engine_halted
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	adc_state_t  state_q;
	logic [2:0]  eng_q;
	logic [31:0] table_q;
	logic [31:0] command_q;
	logic [31:0] desc_addr_q;
	logic [31:0] desc_base_q;
	logic [31:0] desc_ctl_q;
	logic [7:0]  irq_q;
	logic [31:0] codec_stat_q;
	logic        refused_q;
	logic [1:0]  halt_sync_q;
	logic        rd_wait_q;
	logic [31:0] word0;
	logic [31:0] word1;
	logic        desc_legal;
	logic        ctrl_wr;
	logic [7:0]  eng_base;
	logic        eng_dir;

	assign ctrl_wr  = sw_wr && (sw_addr == `ADC_HOST_CTRL) && (state_q == ST_IDLE);
	assign eng_base = `ADC_DEV_ENG_BASE + {2'h0, eng_q, 3'h0};
	assign eng_dir  = eng_q[0];

	// ----------------------------------------------------------------
	// Descriptor packer
	// ----------------------------------------------------------------
	adc_desc_pack u_pack (
		.buf_base (desc_base_q),
		.buf_size ({16'h0, desc_ctl_q[`ADC_DESC_SIZE_W-1:0]}),
		.end_of_table_flag      (desc_ctl_q[`ADC_DESC_EOT]),
		.eop      (desc_ctl_q[`ADC_DESC_EOP]),
		.link     (desc_ctl_q[`ADC_DESC_LINK]),
		.word0    (word0),
		.word1    (word1),
		.legal    (desc_legal)
	);

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	// device-owned timing resampled
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			halt_sync_q <= 2'h0;
		end else begin
			halt_sync_q <= {halt_sync_q[0], engine_halted};
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			table_q     <= 32'h0;
			command_q   <= 32'h0;
			desc_addr_q <= 32'h0;
			desc_base_q <= 32'h0;
			desc_ctl_q  <= 32'h0;
		end else if (sw_wr) begin
			unique case (sw_addr)
				`ADC_HOST_TABLE:     table_q     <= {sw_wdata[31:2], 2'h0};
				`ADC_HOST_COMMAND:   command_q   <= sw_wdata;
				`ADC_HOST_DESC_ADDR: desc_addr_q <= {sw_wdata[31:2], 2'h0};
				`ADC_HOST_DESC_BASE: desc_base_q <= sw_wdata;
				`ADC_HOST_DESC_CTL:  desc_ctl_q  <= sw_wdata;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			eng_q <= 3'h0;
		end else if (ctrl_wr) begin
			eng_q <= sw_wdata[`ADC_CTRL_ENG_HI:`ADC_CTRL_ENG_LO];
		end
	end

	// ----------------------------------------------------------------
	// Software read port
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sw_rdata <= 32'h0;
		end else if (sw_rd) begin
			unique case (sw_addr)
				`ADC_HOST_TABLE:      sw_rdata <= table_q;
				`ADC_HOST_COMMAND:    sw_rdata <= command_q;
				`ADC_HOST_DESC_ADDR:  sw_rdata <= desc_addr_q;
				`ADC_HOST_DESC_BASE:  sw_rdata <= desc_base_q;
				`ADC_HOST_DESC_CTL:   sw_rdata <= desc_ctl_q;
				`ADC_HOST_STATUS:     sw_rdata <= {16'h0, irq_q, 6'h0, refused_q,
					state_q != ST_IDLE};
				`ADC_HOST_CODEC_STAT: sw_rdata <= codec_stat_q;
				default:              sw_rdata <= 32'h0;
			endcase
		end else begin
			sw_rdata <= 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (ctrl_wr) begin
						if (sw_wdata[`ADC_CTRL_START]) begin
							state_q <= ST_CLR_RD;
						end else if (sw_wdata[`ADC_CTRL_STOP]) begin
							state_q <= ST_STOP_WAIT;
						end else if (sw_wdata[`ADC_CTRL_SEND_CMD] &&
							command_q[`ADC_CMD_SEL_HI:`ADC_CMD_SEL_LO] <= `ADC_CMD_SEL_MAX) begin
							state_q <= ST_CMD_WR;
						end else if (sw_wdata[`ADC_CTRL_POLL]) begin
							state_q <= ST_STAT_RD;
						end else if (sw_wdata[`ADC_CTRL_DESC] && desc_legal) begin
							state_q <= ST_DESC_W0;
						end
					end
				end
				ST_CLR_RD:    state_q <= ST_CLR_WAIT;
				ST_CLR_WAIT:  state_q <= ST_PTR_WR;
				ST_PTR_WR:    state_q <= ST_DIR_WR;
				ST_DIR_WR:    state_q <= ST_EN_WR;
				ST_EN_WR:     state_q <= ST_IDLE;
				ST_CMD_WR:    state_q <= ST_IDLE;
				ST_STAT_RD:   state_q <= ST_STAT_WAIT;
				ST_STAT_WAIT: state_q <= ST_IDLE;
				ST_STOP_WAIT: begin
					if (halt_sync_q[1]) begin
						state_q <= ST_STOP_WR;
					end
				end
				ST_STOP_WR:   state_q <= ST_IDLE;
				ST_DESC_W0:   state_q <= ST_DESC_W1;
				ST_DESC_W1:   state_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Refusal flag
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			refused_q <= 1'b0;
		end else if (ctrl_wr) begin
			refused_q <= (sw_wdata[`ADC_CTRL_SEND_CMD] &&
				command_q[`ADC_CMD_SEL_HI:`ADC_CMD_SEL_LO] > `ADC_CMD_SEL_MAX) ||
				(sw_wdata[`ADC_CTRL_DESC] && !desc_legal);
		end
	end

	// ----------------------------------------------------------------
	// Device bus drive
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dev_addr  <= 8'h0;
			dev_wdata <= 32'h0;
			dev_wr    <= 1'b0;
			dev_rd    <= 1'b0;
		end else begin
			dev_wr <= 1'b0;
			dev_rd <= 1'b0;
			unique case (state_q)
				ST_CLR_RD: begin
					dev_addr <= eng_base + `ADC_DEV_ENG_IRQ;
					dev_rd   <= 1'b1;
				end
				ST_PTR_WR: begin
					dev_addr  <= eng_base + `ADC_DEV_ENG_PTR;
					dev_wdata <= table_q;
					dev_wr    <= 1'b1;
				end
				ST_DIR_WR: begin
					dev_addr  <= eng_base + `ADC_DEV_ENG_CMD;
					dev_wdata <= 32'h0;
					dev_wdata[`ADC_ENG_CMD_DIR] <= eng_dir;
					dev_wr    <= 1'b1;
				end
				ST_EN_WR: begin
					dev_addr  <= eng_base + `ADC_DEV_ENG_CMD;
					dev_wdata <= 32'h0;
					dev_wdata[`ADC_ENG_CMD_DIR]    <= eng_dir;
					dev_wdata[`ADC_ENG_CMD_ENABLE] <= 1'b1;
					dev_wr    <= 1'b1;
				end
				ST_CMD_WR: begin
					dev_addr  <= `ADC_DEV_CODEC_COMMAND;
					dev_wdata <= command_q;
					dev_wdata[`ADC_CMD_VALID] <= 1'b1;
					dev_wr    <= 1'b1;
				end
				ST_STAT_RD: begin
					dev_addr <= `ADC_DEV_CODEC_STATUS;
					dev_rd   <= 1'b1;
				end
				ST_STOP_WR: begin
					dev_addr  <= eng_base + `ADC_DEV_ENG_CMD;
					dev_wdata <= 32'h0;
					dev_wdata[`ADC_ENG_CMD_DIR] <= eng_dir;
					dev_wr    <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read capture
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rd_wait_q    <= 1'b0;
			irq_q        <= 8'h0;
			codec_stat_q <= 32'h0;
		end else begin
			rd_wait_q <= dev_rd;
			// Read data stands only in the cycle after the read strobe
			if (rd_wait_q && dev_addr == `ADC_DEV_CODEC_STATUS) begin
				codec_stat_q <= dev_rdata;
			end else if (rd_wait_q) begin
				irq_q <= dev_rdata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Descriptor writes
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mem_addr  <= 32'h0;
			mem_wdata <= 32'h0;
			mem_wr    <= 1'b0;
		end else begin
			mem_wr <= 1'b0;
			if (state_q == ST_DESC_W0) begin
				mem_addr  <= desc_addr_q;
				mem_wdata <= word0;
				mem_wr    <= 1'b1;
			end else if (state_q == ST_DESC_W1) begin
				mem_addr  <= desc_addr_q + 32'h4;
				mem_wdata <= word1;
				mem_wr    <= 1'b1;
			end
		end
	end

endmodule

//--- hw/adc_pkg.sv
// Types shared by the audio descriptor DMA host controller.
// Assumes adc_regs.svh supplies the numeric constants.
package adc_pkg;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_CLR_RD,
		ST_CLR_WAIT,
		ST_PTR_WR,
		ST_DIR_WR,
		ST_EN_WR,
		ST_CMD_WR,
		ST_STAT_RD,
		ST_STAT_WAIT,
		ST_STOP_WAIT,
		ST_STOP_WR,
		ST_DESC_W0,
		ST_DESC_W1
	} adc_state_t;

endpackage

//--- hw/adc_regs.svh
// Offsets and field positions for the audio descriptor DMA host controller.
// Assumes the controlled device decodes byte offsets on its own register port.
//
// Contract
// - A region descriptor is eight bytes: base pointer word, then size and flags word.
// - Software never describes more than 64 KB with one descriptor.
// - The descriptor table sits on a four-byte aligned address.
// - The final descriptor of a table has end-of-table or link set.
// - Enable is cleared only after the engine paused or reached end of table.
// - Reading interrupt status clears bits 1 and 0; read before enabling.
// - Before enabling, command bit 3 matches the engine's fixed direction.
// - Writing one to command bit 0 starts the engine.
// - The codec masters the serial link and supplies its clocks.
// - Command bits 23:22 pick codec, only 00 and 01; bit 16 marks valid.
// - Second descriptor word: 16-bit size, end-of-table 31, end-of-page 30, link.
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

// ----------------------------------------------------------------
// Device register map
// ----------------------------------------------------------------
`define ADC_DEV_GPIO_STATUS   8'h00
`define ADC_DEV_GPIO_CONTROL  8'h04
`define ADC_DEV_CODEC_STATUS  8'h08
`define ADC_DEV_CODEC_COMMAND 8'h0c
`define ADC_DEV_ENG_BASE      8'h20
`define ADC_DEV_ENG_STRIDE    3
`define ADC_DEV_ENG_CMD       8'h00
`define ADC_DEV_ENG_IRQ       8'h01
`define ADC_DEV_ENG_PTR       8'h04
`define ADC_ENG_CMD_ENABLE    0
`define ADC_ENG_CMD_DIR       3
`define ADC_ENG_IRQ_EOP       0
`define ADC_ENG_IRQ_ERR       1
`define ADC_NUM_ENGINES       6

// ----------------------------------------------------------------
// Descriptor layout
// ----------------------------------------------------------------
`define ADC_DESC_BYTES        8
`define ADC_DESC_EOT          31
`define ADC_DESC_EOP          30
`define ADC_DESC_LINK         29
`define ADC_DESC_SIZE_W       16

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define ADC_CMD_ADDR_HI       31
`define ADC_CMD_ADDR_LO       24
`define ADC_CMD_SEL_HI        23
`define ADC_CMD_SEL_LO        22
`define ADC_CMD_VALID         16
`define ADC_CMD_SEL_MAX       2'h1

// ----------------------------------------------------------------
// Host register map (word aligned byte offsets)
// ----------------------------------------------------------------
`define ADC_HOST_CTRL         5'h00
`define ADC_HOST_TABLE        5'h04
`define ADC_HOST_COMMAND      5'h08
`define ADC_HOST_DESC_ADDR    5'h0c
`define ADC_HOST_DESC_BASE    5'h10
`define ADC_HOST_DESC_CTL     5'h14
`define ADC_HOST_STATUS       5'h18
`define ADC_HOST_CODEC_STAT   5'h1c
`define ADC_CTRL_START        0
`define ADC_CTRL_STOP         1
`define ADC_CTRL_SEND_CMD     2
`define ADC_CTRL_POLL         3
`define ADC_CTRL_DESC         4
`define ADC_CTRL_ENG_LO       8
`define ADC_CTRL_ENG_HI       10
`define ADC_STAT_BUSY         0
`define ADC_STAT_REFUSED      1
`define ADC_STAT_IRQ_LO       8

`endif
